// File: design/dsd_pkg.sv
// Package of constants, types and helpers for the DSP subsystem address decoder
package dsd_pkg;

   // ------------------------------------------------------------------
   // Region boundaries, in word addresses
   // ------------------------------------------------------------------
   localparam logic [22:0] DUAL_RAM_LAST_WORD   = 23'h007FFF;  // Dual access RAM, 64K bytes
   localparam logic [22:0] SINGLE_RAM_LAST_WORD = 23'h013FFF;  // Single access RAM, 96K bytes
   localparam logic [22:0] EXT_LAST_WORD        = 23'h7FBFFF;  // End of external path window
   localparam logic [22:0] ROM_FIRST_WORD       = 23'h7FC000;  // Boot ROM window start

   // ------------------------------------------------------------------
   // I/O space layout: 64K words, 1K-word peripheral sections
   // ------------------------------------------------------------------
   localparam int          IO_ADDR_W       = 16;
   localparam int          IO_SEL_MSB      = 15;
   localparam int          IO_SEL_LSB      = 10;
   localparam int          IO_REG_MSB      = 9;
   localparam logic [5:0]  IO_PRIVATE_LAST = 6'h0F;      // Sections 0..15 on private bus
   localparam logic [5:0]  IO_PUBLIC_LAST  = 6'h2F;      // Sections 16..47 on public bus

   // ------------------------------------------------------------------
   // External path: chip select zero base and reset values
   // ------------------------------------------------------------------
   localparam logic [31:0] CS_ZERO_BASE    = 32'h00000000;
   localparam logic [31:0] PHYS_RESET      = 32'h00000000;
   localparam logic [22:0] WORD_RESET      = 23'h000000;

   // ------------------------------------------------------------------
   // Types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      SRC_CORE_PROG,
      SRC_CORE_DATA,
      SRC_DMA,
      SRC_HOST
   } dsd_src_t;

   typedef enum logic [2:0] {
      TGT_NONE,
      TGT_DUAL_RAM,
      TGT_SINGLE_RAM,
      TGT_ROM,
      TGT_EXT,
      TGT_IO
   } dsd_tgt_t;

   typedef enum logic [1:0] {
      BUS_PRIVATE,
      BUS_PUBLIC,
      BUS_SHARED
   } dsd_bus_t;

   // ------------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------------
   // Word address of a request: core data is already word addressed
   function automatic logic [22:0] dsd_word_addr(input dsd_src_t src,
                                                 input logic [23:0] addr);
      if (src == SRC_CORE_DATA) begin
         return addr[22:0];
      end
      return addr[23:1];
   endfunction : dsd_word_addr

   // Byte address of a request
   function automatic logic [23:0] dsd_byte_addr(input dsd_src_t src,
                                                 input logic [23:0] addr);
      if (src == SRC_CORE_DATA) begin
         return {addr[22:0], 1'b0};
      end
      return addr;
   endfunction : dsd_byte_addr

   // Peripheral bus class of an I/O section
   function automatic dsd_bus_t dsd_io_bus(input logic [5:0] sect);
      if (sect <= IO_PRIVATE_LAST) begin
         return BUS_PRIVATE;
      end
      if (sect <= IO_PUBLIC_LAST) begin
         return BUS_PUBLIC;
      end
      return BUS_SHARED;
   endfunction : dsd_io_bus

endpackage : dsd_pkg

// File: design/dsd_xlate.sv
// Address translation stage of the external memory path
module dsd_xlate
   import dsd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        load,
   input  wire logic [23:0] virt_byte,
   input  wire logic        xlt_enable,
   input  wire logic        xlt_configured,
   input  wire logic [31:0] xlt_base,
   output logic             ext_req,
   output logic [31:0]      ext_phys_addr
);

   // ------------------------------------------------------------------
   // Translation
   // ------------------------------------------------------------------
   logic [31:0] next_phys;

   // Virtual to physical, or straight into chip select zero space
   always_comb begin
      if (xlt_enable && xlt_configured) begin
         next_phys = xlt_base + {8'h00, virt_byte};
      end else begin
         next_phys = CS_ZERO_BASE + {8'h00, virt_byte};
      end
   end

   // Request to the traffic controller, one pulse per load
   always_ff @(posedge clk) begin
      if (srst) begin
         ext_req       <= 1'b0;
         ext_phys_addr <= PHYS_RESET;
      end else if (ce) begin
         ext_req <= load;
         if (load) begin
            ext_phys_addr <= next_phys;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   a_bypass_cs_zero: assert property (
      ce && load && !(xlt_enable && xlt_configured)
      |=> ext_req && ext_phys_addr == CS_ZERO_BASE + {8'h00, $past(virt_byte)})
      else $error("untranslated address not in chip select zero");

   a_xlate_base: assert property (
      ce && load && xlt_enable && xlt_configured
      |=> ext_req && ext_phys_addr == $past(xlt_base) + {8'h00, $past(virt_byte)})
      else $error("translated address wrong");

endmodule : dsd_xlate

// File: design/dsd_router.sv
// Address decoder and request router of the DSP subsystem
module dsd_router
   import dsd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ce,
   input  wire logic        req_valid,
   input  dsd_src_t         req_src,
   input  wire logic [23:0] req_addr,
   input  wire logic        req_io,
   input  wire logic        req_byte,
   input  wire logic        rom_map_select,
   input  wire logic        shared_grant_dsp,
   input  wire logic        xlt_enable,
   input  wire logic        xlt_configured,
   input  wire logic [31:0] xlt_base,
   output logic             out_valid,
   output dsd_tgt_t         out_target,
   output logic [22:0]      out_word_addr,
   output logic             out_err,
   output logic             io_private_req,
   output logic             io_public_req,
   output logic             io_shared_req,
   output logic [5:0]       io_periph_sel,
   output logic [9:0]       io_reg_index,
   output logic             ext_req,
   output logic [31:0]      ext_phys_addr
);

   // ------------------------------------------------------------------
   // Address normalisation
   // ------------------------------------------------------------------
   logic [22:0] word_addr;
   logic [23:0] byte_addr;
   logic [5:0]  io_sect;
   logic [9:0]  io_reg;
   dsd_bus_t    io_bus;
   logic        from_core;

   // Core data is word addressed, fetch and DMA are byte addressed
   assign word_addr = dsd_word_addr(req_src, req_addr);
   assign byte_addr = dsd_byte_addr(req_src, req_addr);

   // Section and register index of an I/O word address
   assign io_sect   = req_addr[IO_SEL_MSB:IO_SEL_LSB];
   assign io_reg    = req_addr[IO_REG_MSB:0];
   assign io_bus    = dsd_io_bus(io_sect);
   assign from_core = (req_src == SRC_CORE_PROG) || (req_src == SRC_CORE_DATA);

   // ------------------------------------------------------------------
   // Region decode
   // ------------------------------------------------------------------
   dsd_tgt_t next_target;
   logic     next_err;
   logic     io_allowed;

   // Peripheral bus access rights per requester
   always_comb begin
      io_allowed = 1'b0;
      unique case (io_bus)
         BUS_PRIVATE: io_allowed = from_core;
         BUS_PUBLIC:  io_allowed = 1'b1;
         BUS_SHARED:  begin
            if (req_src == SRC_HOST) begin
               io_allowed = !shared_grant_dsp;
            end else begin
               io_allowed = shared_grant_dsp;
            end
         end
         default:     io_allowed = 1'b0;
      endcase
   end

   // Target selection for one request
   always_comb begin
      next_target = TGT_NONE;
      next_err    = 1'b0;
      if (req_io) begin
         // Separate space, word accesses only
         if (req_byte || !io_allowed) begin
            next_err = 1'b1;
         end else begin
            next_target = TGT_IO;
         end
      end else if (req_src == SRC_HOST) begin
         // Host reaches only the I/O space here
         next_err = 1'b1;
      end else if (word_addr <= DUAL_RAM_LAST_WORD) begin
         next_target = TGT_DUAL_RAM;
      end else if (word_addr <= SINGLE_RAM_LAST_WORD) begin
         next_target = TGT_SINGLE_RAM;
      end else if (word_addr <= EXT_LAST_WORD) begin
         next_target = TGT_EXT;
      end else if (rom_map_select) begin
         next_target = TGT_EXT;
      end else begin
         next_target = TGT_ROM;
      end
   end

   // ------------------------------------------------------------------
   // Registered routing outputs
   // ------------------------------------------------------------------
   // Target, word address and error flag
   always_ff @(posedge clk) begin
      if (srst) begin
         out_valid     <= 1'b0;
         out_target    <= TGT_NONE;
         out_word_addr <= WORD_RESET;
         out_err       <= 1'b0;
      end else if (ce) begin
         out_valid <= req_valid;
         out_err   <= req_valid && next_err;
         if (req_valid) begin
            out_target    <= next_target;
            out_word_addr <= req_io ? {7'h00, req_addr[IO_SEL_MSB:0]} : word_addr;
         end else begin
            out_target <= TGT_NONE;
         end
      end
   end

   // Peripheral bus strobes, only one section at a time
   always_ff @(posedge clk) begin
      if (srst) begin
         io_private_req <= 1'b0;
         io_public_req  <= 1'b0;
         io_shared_req  <= 1'b0;
         io_periph_sel  <= 6'h00;
         io_reg_index   <= 10'h000;
      end else if (ce) begin
         io_private_req <= req_valid && next_target == TGT_IO && io_bus == BUS_PRIVATE;
         io_public_req  <= req_valid && next_target == TGT_IO && io_bus == BUS_PUBLIC;
         io_shared_req  <= req_valid && next_target == TGT_IO && io_bus == BUS_SHARED;
         if (req_valid && next_target == TGT_IO) begin
            io_periph_sel <= io_sect;
            io_reg_index  <= io_reg;
         end
      end
   end

   // ------------------------------------------------------------------
   // External memory port
   // ------------------------------------------------------------------
   logic ext_load;

   // The only way out to external memory
   assign ext_load = req_valid && next_target == TGT_EXT;

   dsd_xlate u_xlate (
      .clk            (clk),
      .srst           (srst),
      .ce             (ce),
      .load           (ext_load),
      .virt_byte      (byte_addr),
      .xlt_enable     (xlt_enable),
      .xlt_configured (xlt_configured),
      .xlt_base       (xlt_base),
      .ext_req        (ext_req),
      .ext_phys_addr  (ext_phys_addr)
   );

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (srst);

   logic mem_req;
   assign mem_req = ce && req_valid && !req_io && req_src != SRC_HOST;

   a_dual_ram_route: assert property (
      mem_req && word_addr <= 23'h007FFF
      |=> out_target == TGT_DUAL_RAM && out_word_addr == $past(word_addr) && !ext_req)
      else $error("dual access RAM window misrouted");

   a_single_ram_route: assert property (
      mem_req && word_addr >= 23'h008000 && word_addr <= 23'h013FFF
      |=> out_target == TGT_SINGLE_RAM && !ext_req)
      else $error("single access RAM window misrouted");

   a_ext_route: assert property (
      mem_req && word_addr >= 23'h014000 && word_addr <= 23'h7FBFFF
      |=> out_target == TGT_EXT && ext_req)
      else $error("external window misrouted");

   a_rom_select: assert property (
      mem_req && word_addr >= 23'h7FC000
      |=> (out_target == TGT_ROM) == !$past(rom_map_select)
          && ext_req == $past(rom_map_select))
      else $error("top region ignores ROM map select");

   a_ext_only_port: assert property (
      ext_req |-> out_valid && out_target == TGT_EXT && !out_err)
      else $error("external request without external target");

   a_io_one_bus: assert property (
      $onehot0({io_private_req, io_public_req, io_shared_req})
      && (io_private_req || io_public_req || io_shared_req) == (out_target == TGT_IO))
      else $error("I/O access selects more than one bus");

   a_io_no_byte: assert property (
      ce && req_valid && req_io && req_byte |=> out_err && out_target == TGT_NONE)
      else $error("byte I/O access was accepted");

   a_private_core: assert property (
      io_private_req && $past(ce) |-> $past(from_core))
      else $error("private peripheral reached by non-core master");

   a_shared_grant: assert property (
      io_shared_req && $past(ce) |-> $past(shared_grant_dsp) == ($past(req_src) != SRC_HOST))
      else $error("shared peripheral access without grant");

   a_dma_byte: assert property (
      mem_req && req_src == SRC_DMA
      |=> out_word_addr == $past(req_addr[23:1]))
      else $error("DMA address not treated as byte address");

   a_io_fields: assert property (
      ce && req_valid && req_io && !req_byte && io_allowed
      |=> io_periph_sel == $past(req_addr[15:10]) && io_reg_index == $past(req_addr[9:0]))
      else $error("peripheral section fields wrong");

   // Address forms per requester
   a_core_data_word: assert property (
      mem_req && req_src == SRC_CORE_DATA
      |=> out_word_addr == $past(req_addr[22:0]))
      else $error("core data address not treated as word address");

   a_core_prog_byte: assert property (
      mem_req && req_src == SRC_CORE_PROG
      |=> out_word_addr == $past(req_addr[23:1]))
      else $error("program fetch address not treated as byte address");

   a_ext_cs_zero: assert property (
      mem_req && req_src == SRC_CORE_DATA && !(xlt_enable && xlt_configured)
      && word_addr >= 23'h014000 && word_addr <= 23'h7FBFFF
      |=> ext_req && ext_phys_addr == CS_ZERO_BASE + {8'h00, $past(req_addr[22:0]), 1'b0})
      else $error("core data external byte address wrong");

   // Peripheral section rights, refusals and strobes
   a_public_open: assert property (
      ce && req_valid && req_io && !req_byte
      && req_addr[15:10] >= 6'h10 && req_addr[15:10] <= 6'h2F
      |=> io_public_req && !out_err)
      else $error("public peripheral refused to a master");

   a_private_refused: assert property (
      ce && req_valid && req_io && !from_core && req_addr[15:10] <= 6'h0F
      |=> out_err && !io_private_req)
      else $error("non-core private access not refused");

   a_shared_refused: assert property (
      ce && req_valid && req_io && req_addr[15:10] >= 6'h30
      && shared_grant_dsp == (req_src == SRC_HOST)
      |=> out_err && !io_shared_req)
      else $error("shared peripheral reached without grant");

   a_io_no_ext: assert property (
      ce && req_valid && req_io
      |=> !ext_req && (out_target == TGT_IO || out_target == TGT_NONE))
      else $error("I/O access left the I/O space");

   a_io_word_addr: assert property (
      ce && req_valid && req_io
      |=> out_word_addr == {7'h00, $past(req_addr[15:0])})
      else $error("I/O word address wrong");

   a_idle_quiet: assert property (
      ce && !req_valid
      |=> !out_valid && !ext_req && !io_private_req && !io_public_req && !io_shared_req)
      else $error("strobe without a request");

   a_err_no_strobe: assert property (
      out_err |-> out_target == TGT_NONE && !ext_req
                  && !io_private_req && !io_public_req && !io_shared_req)
      else $error("refused access still selected a target");

   c_ext_access:    cover property (ext_req);
   c_private_access: cover property (io_private_req);
   c_rom_access:    cover property (out_target == TGT_ROM);
   c_shared_access: cover property (io_shared_req);
   c_io_refused:    cover property (out_err && $past(req_io));

endmodule : dsd_router

// File: bench/dsd_tc_model.sv
// Behavioural traffic controller on the far side of the external path
module dsd_tc_model
   import dsd_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        ext_req,
   input  wire logic [31:0] ext_phys_addr,
   output logic [2:0]       port_used,
   output logic [15:0]      served
);
   timeunit 1ns;
   timeprecision 1ps;

   // Each forwarded access lands on exactly one system memory port
   always_ff @(posedge clk) begin
      if (srst) begin
         port_used <= 3'h0;
         served    <= 16'h0000;
      end else if (ext_req) begin
         served <= served + 16'h0001;
         if (ext_phys_addr < 32'h01000000) begin
            port_used <= 3'h2;  // Slow external port
         end else if (ext_phys_addr[31:28] == 4'h1) begin
            port_used <= 3'h4;  // Fast external port
         end else begin
            port_used <= 3'h1;  // System internal port
         end
      end
   end
endmodule : dsd_tc_model

// File: bench/tb.sv
// Self-checking testbench of the address decoder and router
module tb
   import dsd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   $display("wrong value %s exp %0h got %0h", nm, e, g); n_fail++; end end
   // ------------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------------
   logic        clk, srst, ce, req_valid, req_io, req_byte, rom_map_select;
   logic        shared_grant_dsp, xlt_enable, xlt_configured, out_valid, out_err;
   logic        io_private_req, io_public_req, io_shared_req, ext_req;
   dsd_src_t    req_src;
   dsd_tgt_t    out_target;
   logic [23:0] req_addr;
   logic [31:0] xlt_base, ext_phys_addr;
   logic [22:0] out_word_addr;
   logic [5:0]  io_periph_sel;
   logic [9:0]  io_reg_index;
   logic [2:0]  port_used;
   logic [15:0] served, n_ext;
   int          n_fail, num_checks;

   dsd_router u_dsd_router (.clk(clk), .srst(srst), .ce(ce), .req_valid(req_valid),
      .req_src(req_src), .req_addr(req_addr), .req_io(req_io), .req_byte(req_byte),
      .rom_map_select(rom_map_select), .shared_grant_dsp(shared_grant_dsp),
      .xlt_enable(xlt_enable), .xlt_configured(xlt_configured), .xlt_base(xlt_base),
      .out_valid(out_valid), .out_target(out_target), .out_word_addr(out_word_addr),
      .out_err(out_err), .io_private_req(io_private_req), .io_public_req(io_public_req),
      .io_shared_req(io_shared_req), .io_periph_sel(io_periph_sel),
      .io_reg_index(io_reg_index), .ext_req(ext_req), .ext_phys_addr(ext_phys_addr));
   dsd_tc_model u_dsd_tc_model (.clk(clk), .srst(srst), .ext_req(ext_req),
      .ext_phys_addr(ext_phys_addr), .port_used(port_used), .served(served));

   // ------------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------------
   // One request, driven at the next edge and taken at the one after, answer settled after it
   task automatic issue(input dsd_src_t s, input logic [23:0] a, input logic io,
                        input logic byt);
      @(posedge clk);
      req_valid <= 1'b1;
      req_src   <= s;
      req_addr  <= a;
      req_io    <= io;
      req_byte  <= byt;
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
   endtask : issue

   // Memory request with expected target, word and physical address
   task automatic mem(input dsd_src_t s, input logic [23:0] a, input dsd_tgt_t t,
                      input logic [22:0] w, input logic [31:0] p);
      issue(s, a, 1'b0, 1'b0);
      `CHK("out_valid", 1'b1, out_valid)
      `CHK("out_target", t, out_target)
      `CHK("out_err", t == TGT_NONE, out_err)
      `CHK("ext_req", t == TGT_EXT, ext_req)
      if (t != TGT_NONE) `CHK("out_word_addr", w, out_word_addr)
      if (t == TGT_EXT) begin
         n_ext++;
         `CHK("ext_phys_addr", p, ext_phys_addr)
      end
   endtask : mem

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   // Region boundaries for every requester, ROM in place
   task automatic t_regions();
      `CHK("reset target", TGT_NONE, out_target)
      mem(SRC_CORE_DATA, 24'h007FFF, TGT_DUAL_RAM, 23'h007FFF, 0);
      mem(SRC_CORE_DATA, 24'h008000, TGT_SINGLE_RAM, 23'h008000, 0);
      mem(SRC_CORE_PROG, 24'h027FFF, TGT_SINGLE_RAM, 23'h013FFF, 0);
      mem(SRC_DMA, 24'h00FFFF, TGT_DUAL_RAM, 23'h007FFF, 0);
      mem(SRC_DMA, 24'h028000, TGT_EXT, 23'h014000, CS_ZERO_BASE + 32'h028000);
      mem(SRC_CORE_PROG, 24'hFF7FFE, TGT_EXT, 23'h7FBFFF,
          CS_ZERO_BASE + 32'hFF7FFE);
      mem(SRC_CORE_DATA, 24'h7FC000, TGT_ROM, 23'h7FC000, 0);
      mem(SRC_DMA, 24'hFFFFFF, TGT_ROM, 23'h7FFFFF, 0);
      mem(SRC_HOST, 24'h000100, TGT_NONE, 0, 0);
      `CHK("slow port", 3'h2, port_used)
      $display("test regions done");
   endtask : t_regions

   // Remapped top region, then translation off, half on and on
   task automatic t_remap_xlate();
      rom_map_select <= 1'b1;
      mem(SRC_DMA, 24'hFF8000, TGT_EXT, 23'h7FC000, CS_ZERO_BASE + 32'hFF8000);
      mem(SRC_CORE_DATA, 24'h7FC001, TGT_EXT, 23'h7FC001,
          CS_ZERO_BASE + 32'hFF8002);
      xlt_enable <= 1'b1;
      mem(SRC_DMA, 24'h050000, TGT_EXT, 23'h028000, CS_ZERO_BASE + 32'h050000);
      xlt_configured <= 1'b1;
      mem(SRC_DMA, 24'h050000, TGT_EXT, 23'h028000, 32'h10050000);
      mem(SRC_CORE_PROG, 24'h0A0002, TGT_EXT, 23'h050001, 32'h100A0002);
      rom_map_select <= 1'b0;
      xlt_enable <= 1'b0;
      repeat (2) @(posedge clk);
      `CHK("served", n_ext, served)
      `CHK("port", 3'h4, port_used)
      $display("test remap and translation done");
   endtask : t_remap_xlate

   // I/O sections by bus class, requester, grant and width
   task automatic t_io();
      dsd_src_t    s[11] = '{SRC_CORE_DATA, SRC_DMA, SRC_HOST, SRC_CORE_PROG, SRC_DMA,
         SRC_HOST, SRC_CORE_DATA, SRC_CORE_DATA, SRC_HOST, SRC_DMA, SRC_CORE_DATA};
      logic [15:0] a[11] = '{16'h03FF, 16'h0000, 16'h3C00, 16'h4C05, 16'h4000, 16'hBFFF,
         16'hC000, 16'hC000, 16'hFFFF, 16'hFC00, 16'h4000};
      logic [10:0] g = 11'b00001000000;
      logic [10:0] byt = 11'b10000000000;
      logic [2:0]  st[11] = '{3'h1, 3'h0, 3'h0, 3'h2, 3'h2, 3'h2, 3'h4, 3'h0, 3'h4, 3'h0,
         3'h0};
      for (int i = 0; i < 11; i++) begin
         shared_grant_dsp <= g[i];
         issue(s[i], {8'h00, a[i]}, 1'b1, byt[i]);
         `CHK("io strobes", st[i], {io_shared_req, io_public_req, io_private_req})
         `CHK("io err", st[i] == 3'h0, out_err)
         `CHK("io target", st[i] == 3'h0 ? TGT_NONE : TGT_IO, out_target)
         `CHK("ext idle", 1'b0, ext_req)
         if (st[i] != 3'h0) begin
            `CHK("periph sel", a[i][15:10], io_periph_sel)
            `CHK("reg index", a[i][9:0], io_reg_index)
         end
      end
      $display("test io space done");
   endtask : t_io

   // Back-to-back requests, then a request under clock enable low
   task automatic t_pipeline();
      @(posedge clk);
      req_valid <= 1'b1;
      req_io    <= 1'b0;
      req_src   <= SRC_DMA;
      req_addr  <= 24'h000010;
      @(posedge clk);
      req_addr  <= 24'h020000;
      #1;
      `CHK("first target", TGT_DUAL_RAM, out_target)
      @(posedge clk);
      req_valid <= 1'b0;
      #1;
      `CHK("second target", TGT_SINGLE_RAM, out_target)
      `CHK("second word", 23'h010000, out_word_addr)
      @(posedge clk);
      ce        <= 1'b0;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      ce        <= 1'b1;
      #1;
      `CHK("frozen valid", 1'b0, out_valid)
      $display("test pipeline done");
   endtask : t_pipeline

   // ------------------------------------------------------------------
   // Run control
   // ------------------------------------------------------------------
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : summarize

   // Clock generator
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // Watchdog against a hung run
   initial begin
      #(8 * 5000);
      n_fail++;
      summarize();
   end

   // Reset, then the scenarios in order
   initial begin
      {srst, ce, req_valid, req_io, req_byte, rom_map_select} = 6'b110000;
      {shared_grant_dsp, xlt_enable, xlt_configured} = 3'b000;
      req_src = SRC_CORE_DATA;
      req_addr = 24'h000000;
      xlt_base = 32'h10000000;
      {n_ext, n_fail, num_checks} = 0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      #1;
      t_regions();
      t_remap_xlate();
      t_io();
      t_pipeline();
      summarize();
   end
endmodule : tb
